// *** rotate_left_pkg.sv ***
package rotate_left_pkg;
  // -------------------------------------------------------------------
  // opcode fields
  // -------------------------------------------------------------------
  localparam logic [5:0] OPC_PLAIN      = 6'h11;
  localparam logic [5:0] OPC_THRU       = 6'h0d;
  localparam int         OPC_MSB        = 15;
  localparam int         OPC_LSB        = 10;
  localparam int         DEST_BIT       = 9;
  localparam int         ACC_BIT        = 8;
  // -------------------------------------------------------------------
  // addressing
  // -------------------------------------------------------------------
  localparam logic [7:0] INDEX_LIMIT    = 8'h5f;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  // -------------------------------------------------------------------
  // reset values, clock period and phase count
  // -------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [11:0] RST_ADDR      = 12'h000;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          PHASES        = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_Q1,
    ST_Q2,
    ST_Q3,
    ST_Q4
  } phase_t;
endpackage

// *** rot_if.sv ***
`timescale 1ns/10ps
interface rot_if;
  logic [7:0] opnd;
  logic       cin;
  logic       thru;
  logic [7:0] result;
  logic       cout;
  logic       neg;
  logic       zero;

  modport unit (
    input  opnd,
    input  cin,
    input  thru,
    output result,
    output cout,
    output neg,
    output zero
  );
  modport user (
    output opnd,
    output cin,
    output thru,
    input  result,
    input  cout,
    input  neg,
    input  zero
  );
endinterface

// *** rotl_unit.sv ***
`timescale 1ns/10ps
module rotl_unit (
  rot_if.unit r
);
  logic [7:0] res;

  always_comb begin
    res      = {r.opnd[6:0], r.thru ? r.cin : r.opnd[7]};
    r.result = res;
    r.cout   = r.thru ? r.opnd[7] : r.cin;
    r.neg    = res[7];
    r.zero   = (res == 8'h00);
  end
endmodule

// *** rotate_left_exec.sv ***
`timescale 1ns/10ps
module rotate_left_exec
  import rotate_left_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic              i_instr_valid,
  input  wire logic [15:0]       i_instr,
  input  wire logic              i_ext_isa_en,
  input  wire logic [ADDR_W-9:0] i_bank_select_reg,
  input  wire logic [ADDR_W-1:0] i_index_base,
  input  wire logic              i_carry,
  input  wire logic [7:0]        i_mem_rdata,
  output logic                   o_busy,
  output logic                   o_illegal,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic                   o_wreg_we,
  output logic [7:0]             o_result,
  output logic                   o_flags_we,
  output logic                   o_carry_we,
  output logic                   o_carry,
  output logic                   o_neg,
  output logic                   o_zero,
  output logic                   o_done
);
  // -------------------------------------------------------------------
  // captured instruction
  // -------------------------------------------------------------------
  phase_t            state_q;
  logic [7:0]        f_q;
  logic              dest_q;
  logic              acc_q;
  logic              plain_q;
  logic              idx_q;
  logic              cin_q;
  logic [7:0]        opnd_q;
  logic [ADDR_W-9:0] bank_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] addr_d;
  logic              is_plain;
  logic              is_thru;

  assign is_plain = (i_instr[OPC_MSB:OPC_LSB] == OPC_PLAIN);
  assign is_thru  = (i_instr[OPC_MSB:OPC_LSB] == OPC_THRU);

  rot_if rif ();

  assign rif.opnd = opnd_q;
  assign rif.cin  = cin_q;
  assign rif.thru = !plain_q;

  rotl_unit u_rot (
    .r (rif.unit)
  );

  // -------------------------------------------------------------------
  // phase sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (i_instr_valid && (is_plain || is_thru)) begin
            state_q <= ST_Q1;
          end
        end
        ST_Q1:   state_q <= ST_Q2;
        ST_Q2:   state_q <= ST_Q3;
        ST_Q3:   state_q <= ST_Q4;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      f_q     <= RST_BYTE;
      dest_q  <= 1'b1;
      acc_q   <= 1'b0;
      plain_q <= 1'b1;
    end else if (i_ce && state_q == ST_IDLE && i_instr_valid) begin
      f_q     <= i_instr[7:0];
      dest_q  <= i_instr[DEST_BIT];
      acc_q   <= i_instr[ACC_BIT];
      plain_q <= is_plain;
    end
  end

  // copies taken with the address, so the rotate and the checks use
  // the bank, base and carry of the decode phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      bank_q <= '0;
      base_q <= '0;
      cin_q  <= 1'b0;
      idx_q  <= 1'b0;
    end else if (i_ce && state_q == ST_Q1) begin
      bank_q <= i_bank_select_reg;
      base_q <= i_index_base;
      cin_q  <= i_carry;
      idx_q  <= i_ext_isa_en && !acc_q && (f_q <= INDEX_LIMIT);
    end
  end

  // -------------------------------------------------------------------
  // operand address
  // -------------------------------------------------------------------
  always_comb begin
    if (acc_q) begin
      addr_d = {i_bank_select_reg, f_q};
    end else if (i_ext_isa_en && f_q <= INDEX_LIMIT) begin
      addr_d = ADDR_W'(i_index_base + ADDR_W'(f_q));
    end else if (f_q <= INDEX_LIMIT) begin
      addr_d = ADDR_W'({ACCESS_LO_BANK, f_q});
    end else begin
      addr_d       = '1;
      addr_d[11:0] = {ACCESS_HI_BANK, f_q};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mem_addr <= ADDR_W'(RST_ADDR);
      o_mem_rd   <= 1'b0;
    end else if (i_ce) begin
      if (state_q == ST_Q1) begin
        o_mem_addr <= addr_d;
      end
      o_mem_rd <= (state_q == ST_Q1);
    end
  end

  // read data is taken at the edge that closes the read phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      opnd_q <= RST_BYTE;
    end else if (i_ce && state_q == ST_Q2) begin
      opnd_q <= i_mem_rdata;
    end
  end

  // -------------------------------------------------------------------
  // write back and flags
  // -------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_result   <= RST_BYTE;
      o_mem_wr   <= 1'b0;
      o_wreg_we  <= 1'b0;
      o_flags_we <= 1'b0;
      o_carry_we <= 1'b0;
      o_carry    <= 1'b0;
      o_neg      <= 1'b0;
      o_zero     <= 1'b0;
      o_done     <= 1'b0;
    end else if (i_ce) begin
      if (state_q == ST_Q3) begin
        o_result <= rif.result;
        o_carry  <= rif.cout;
        o_neg    <= rif.neg;
        o_zero   <= rif.zero;
      end
      o_mem_wr   <= (state_q == ST_Q3) && dest_q;
      o_wreg_we  <= (state_q == ST_Q3) && !dest_q;
      o_flags_we <= (state_q == ST_Q3);
      o_carry_we <= (state_q == ST_Q3) && !plain_q;
      o_done     <= (state_q == ST_Q3);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_busy    <= 1'b0;
      o_illegal <= 1'b0;
    end else if (i_ce) begin
      o_busy    <= (state_q == ST_IDLE) ? (i_instr_valid &&
                   (is_plain || is_thru)) : (state_q != ST_Q4);
      o_illegal <= (state_q == ST_IDLE) && i_instr_valid &&
                   !is_plain && !is_thru;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  a_plain_rot: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (state_q == ST_Q4 && plain_q) |->
      o_result == {opnd_q[6:0], opnd_q[7]})
    else $error("plain rotate result wrong");

  a_thru_rot: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (state_q == ST_Q4 && !plain_q) |->
      (o_result == {opnd_q[6:0], cin_q} && o_carry == opnd_q[7]))
    else $error("carry rotate result wrong");

  a_carry_kept: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    o_flags_we |-> (o_carry_we == !plain_q))
    else $error("carry write on plain rotate");

  a_carry_echo: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_flags_we && plain_q) |-> (!o_carry_we && o_carry == cin_q))
    else $error("plain rotate altered carry");

  a_nz_flags: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    o_flags_we |->
      (o_neg == o_result[7] && o_zero == (o_result == 8'h00)))
    else $error("negative or zero flag wrong");

  a_dest_sel: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (state_q == ST_Q4) |->
      (o_mem_wr == dest_q && o_wreg_we == !dest_q))
    else $error("destination select wrong");

  a_bank_addr: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_mem_rd && acc_q) |-> o_mem_addr == {bank_q, f_q})
    else $error("banked address wrong");

  a_indexed: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_mem_rd && idx_q) |->
      o_mem_addr == ADDR_W'(base_q + {{(ADDR_W-8){1'b0}}, f_q}))
    else $error("indexed address wrong");

  a_phase_seq: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (state_q == ST_Q1 && i_ce) ##1 i_ce ##1 i_ce |=>
      (state_q == ST_Q4 && o_done))
    else $error("phase sequence broken");

  a_decode: assert property (
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_ce && state_q == ST_IDLE && i_instr_valid &&
     i_instr[OPC_MSB:OPC_LSB] == OPC_PLAIN) |=>
      (state_q == ST_Q1 && plain_q))
    else $error("plain opcode not decoded");
endmodule

// *** mem_model.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// data memory seen by the rotate block
// ---------------------------------------------------------------
module mem_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_q = 8'h00;
  // outside a read the bus shows the inverse, so stale data never passes
  always_comb o_rdata = i_rd ? mem[i_addr] : ~last_q;
  always @(posedge i_mclk) begin
    if (i_rd) last_q <= mem[i_addr];
    if (i_wr) mem[i_addr] <= i_wdata;
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import rotate_left_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic        i_ext_isa_en = 1'b0;
  logic [3:0]  i_bank_select_reg = 4'h0;
  logic [11:0] i_index_base = 12'h200;
  logic        i_carry = 1'b0;
  logic [7:0]  i_mem_rdata;
  logic        o_busy, o_illegal, o_mem_rd, o_mem_wr, o_wreg_we;
  logic        o_flags_we, o_carry_we, o_carry, o_neg, o_zero, o_done;
  logic [11:0] o_mem_addr;
  logic [7:0]  o_result;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          stall = 0;

  rotate_left_exec #(.ADDR_W(12)) u_rotate_left_exec (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_ext_isa_en(i_ext_isa_en), .i_bank_select_reg(i_bank_select_reg),
    .i_index_base(i_index_base), .i_carry(i_carry),
    .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_illegal(o_illegal),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_wreg_we(o_wreg_we), .o_result(o_result), .o_flags_we(o_flags_we),
    .o_carry_we(o_carry_we), .o_carry(o_carry), .o_neg(o_neg),
    .o_zero(o_zero), .o_done(o_done));
  mem_model u_mem (
    .i_mclk(i_mclk), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_addr(o_mem_addr), .i_wdata(o_result), .o_rdata(i_mem_rdata));

  initial begin
    forever #(CLK_PERIOD_NS / 2) i_mclk = ~i_mclk;
  end
  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] t=%0t %s", $time, m);
    end
  endtask
  // one rotate: thru, dest, access, f, ext, bank, address, byte, carry
  task automatic go(input logic th, input logic d, input logic a,
    input logic [7:0] f, input logic x, input logic [3:0] bk,
    input logic [11:0] adr, input logic [7:0] v, input logic c);
    logic [7:0] r;
    int n;
    r = {v[6:0], th ? c : v[7]};
    u_mem.mem[adr] = v;
    i_instr = {th ? OPC_THRU : OPC_PLAIN, d, a, f};
    i_ext_isa_en = x;
    i_bank_select_reg = bk;
    i_carry = c;
    i_instr_valid = 1'b1;
    n = 0;
    while (o_busy !== 1'b1 && n < 20) begin
      @(posedge i_mclk); #1;
      n++;
    end
    i_instr_valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20) begin
      // freeze the read phase for stall cycles
      i_ce = !(n >= 1 && n < 1 + stall);
      @(posedge i_mclk); #1;
      n++;
    end
    i_ce = 1'b1;
    chk(n == PHASES - 1 + stall, "latency");
    chk(o_mem_addr === adr, "address");
    chk(o_result === r, "result");
    chk(o_neg === r[7] && o_zero === (r == 8'h00), "flags");
    chk(o_flags_we === 1'b1, "flag strobe");
    chk(o_carry_we === th && o_carry === (th ? v[7] : c), "carry");
    chk(o_mem_wr === d && o_wreg_we === !d, "destination");
    @(posedge i_mclk); #1;
    chk(u_mem.mem[adr] === (d ? r : v), "writeback");
    $display("test at %0t done", $time);
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    go(1'b0, 1'b1, 1'b0, 8'h10, 1'b0, 4'h0, 12'h010, 8'hab, 1'b1);
    go(1'b1, 1'b0, 1'b0, 8'h20, 1'b0, 4'h0, 12'h020, 8'he6, 1'b0);
    go(1'b0, 1'b1, 1'b1, 8'h80, 1'b0, 4'h5, 12'h580, 8'h80, 1'b0);
    go(1'b0, 1'b0, 1'b0, 8'h60, 1'b0, 4'h0, 12'hf60, 8'h00, 1'b1);
    go(1'b0, 1'b1, 1'b0, 8'h5f, 1'b1, 4'h0, 12'h25f, 8'h40, 1'b0);
    go(1'b0, 1'b1, 1'b0, 8'h60, 1'b1, 4'h0, 12'hf60, 8'hc3, 1'b0);
    go(1'b1, 1'b1, 1'b1, 8'hff, 1'b0, 4'hf, 12'hfff, 8'h01, 1'b1);
    go(1'b1, 1'b1, 1'b0, 8'h00, 1'b1, 4'h3, 12'h200, 8'h81, 1'b1);
    stall = 3;
    go(1'b1, 1'b1, 1'b0, 8'h30, 1'b0, 4'h0, 12'h030, 8'h7f, 1'b1);
    stall = 0;
    // neighbouring right-rotate word must not be taken
    i_instr = 16'h4000;
    i_instr_valid = 1'b1;
    @(posedge i_mclk); #1;
    i_instr_valid = 1'b0;
    chk(o_illegal === 1'b1 && o_busy === 1'b0, "refuse");
    @(posedge i_mclk); #1;
    chk(o_illegal === 1'b0 && o_busy === 1'b0, "pulse");
    $display("test at %0t done", $time);
    // reset in mid instruction, then a clean rotate
    i_instr = {OPC_PLAIN, 1'b1, 1'b0, 8'h10};
    i_instr_valid = 1'b1;
    @(posedge i_mclk); #1;
    i_instr_valid = 1'b0;
    i_sys_rst = 1'b1;
    @(posedge i_mclk); #1;
    i_sys_rst = 1'b0;
    chk(o_busy === 1'b0 && o_mem_rd === 1'b0, "reset");
    go(1'b0, 1'b0, 1'b0, 8'h10, 1'b0, 4'h0, 12'h010, 8'h96, 1'b0);
    summarize();
  end
endmodule
